// ---- cbd_pkg.sv ----
package cbd_pkg;

  // Phases of double_clk inside one T-state; a flop loaded at the end of
  // phase N shows its new value in phase N+1.
  localparam logic [1:0] PH_FIRST   = 2'h0;
  localparam logic [1:0] PH_READY   = 2'h0;
  localparam logic [1:0] PH_S8_SET  = 2'h2;
  localparam logic [1:0] PH_S8_CLR  = 2'h0;
  localparam logic [1:0] PH_LAST    = 2'h3;

  // Wait states in T-states per access class
  localparam logic [3:0] WAIT_DRAM  = 4'h2;
  localparam logic [3:0] WAIT_FLASH = 4'h2;
  localparam logic [3:0] WAIT_HALT  = 4'h8;
  localparam logic [3:0] WAIT_SEB16 = 4'h8;
  localparam logic [3:0] WAIT_SEB8  = 4'hf;
  localparam logic [3:0] WAIT_NONE  = 4'h0;

  // Phases elapsed since the cycle was taken
  localparam logic [5:0] EL_COL     = 6'h01;
  localparam logic [5:0] EL_CAS     = 6'h02;
  localparam logic [5:0] EL_REF_RAS = 6'h01;
  localparam logic [5:0] EL_CMD     = 6'h02;
  localparam logic [5:0] EL_MAX     = 6'h3f;

  // Address bits that pick the DRAM bank
  localparam int unsigned BANK_BIT_SMALL = 19;
  localparam int unsigned BANK_BIT_LARGE = 23;

  // Chip select indices
  localparam int unsigned SEL_KBD   = 1;
  localparam int unsigned SEL_RTC   = 2;
  localparam int unsigned SEL_IDE1  = 3;
  localparam int unsigned SEL_IDE0  = 4;
  localparam int unsigned SEL_DRAM  = 5;
  localparam int unsigned SEL_FLASH = 6;

  // I/O byte address ranges of the general selects
  localparam logic [15:0] IO_KBD_A  = 16'h0060;
  localparam logic [15:0] IO_KBD_B  = 16'h0064;
  localparam logic [15:0] IO_RTC_LO = 16'h0070;
  localparam logic [15:0] IO_RTC_HI = 16'h0071;
  localparam logic [15:0] IO_ID1_LO = 16'h03f6;
  localparam logic [15:0] IO_ID1_HI = 16'h03f7;
  localparam logic [15:0] IO_ID0_LO = 16'h01f0;
  localparam logic [15:0] IO_ID0_HI = 16'h01f7;

  // Cycle type, coded as {mem_or_io, data_or_ctrl, write_or_read}
  typedef enum logic [2:0] {
    CYC_INTA    = 3'b000,
    CYC_RSVD    = 3'b001,
    CYC_IO_RD   = 3'b010,
    CYC_IO_WR   = 3'b011,
    CYC_CODE_RD = 3'b100,
    CYC_HALT    = 3'b101,
    CYC_MEM_RD  = 3'b110,
    CYC_MEM_WR  = 3'b111
  } cbd_cyc_e;

  // Byte enables, coded as {byte_high_en_n, byte_low_en_n}
  typedef enum logic [1:0] {
    BYTES_WORD    = 2'b00,
    BYTES_UPPER   = 2'b01,
    BYTES_LOWER   = 2'b10,
    BYTES_REFRESH = 2'b11
  } cbd_bytes_e;

  // Memory region the processor selects for a memory cycle
  typedef enum logic [1:0] {
    MSEL_NONE  = 2'b00,
    MSEL_DRAM  = 2'b01,
    MSEL_FLASH = 2'b10,
    MSEL_TOP   = 2'b11
  } cbd_msel_e;

endpackage

// ---- cbd_if.sv ----
`timescale 1ns/1ns
interface cbd_if;
  logic        addr_strobe_n;
  logic [23:1] addr;
  logic        write_or_read;
  logic        data_or_ctrl;
  logic        mem_or_io;
  logic        byte_high_en_n;
  logic        byte_low_en_n;
  logic [6:1]  gen_sel_n;
  logic        upper_sel_n;
  logic        local_access_n;
  logic        cpu_reset;
  logic        dev_ready_o;
  logic        dev_ready_oe;
  logic        host_ready_o;
  logic        host_ready_oe;
  logic        ready_line;
  logic        next_addr_n;
  logic        size8_n;

  // Shared ready wire with pull-up
  assign ready_line = dev_ready_oe ? dev_ready_o : (host_ready_oe ? host_ready_o : 1'b1);

  modport dev (
    input  addr_strobe_n, addr, write_or_read, data_or_ctrl, mem_or_io,
    input  byte_high_en_n, byte_low_en_n, gen_sel_n, upper_sel_n, local_access_n,
    input  ready_line,
    output cpu_reset, dev_ready_o, dev_ready_oe, next_addr_n, size8_n
  );

  modport host (
    output addr_strobe_n, addr, write_or_read, data_or_ctrl, mem_or_io,
    output byte_high_en_n, byte_low_en_n, gen_sel_n, upper_sel_n, local_access_n,
    output host_ready_o, host_ready_oe,
    input  ready_line, cpu_reset, next_addr_n, size8_n
  );
endinterface // cbd_if

// ---- cbd_host.sv ----
`timescale 1ns/1ns
module cbd_host #(
  parameter bit BOOT_8BIT = 1'b0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Processor bus
  cbd_if.host                   bus,
  // Request
  input  wire logic             req_valid,
  input  wire cbd_pkg::cbd_cyc_e   req_cyc,
  input  wire cbd_pkg::cbd_bytes_e req_bytes,
  input  wire logic [23:1]      req_addr,
  input  wire logic             req_local,
  input  wire cbd_pkg::cbd_msel_e  req_mem,
  // Answer
  output logic                  req_ready,
  output logic                  done,
  output logic                  done_size8
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_T1   = 2'b01,
    HS_T2   = 2'b10
  } cbd_hstate_e;

  cbd_hstate_e st_ff;
  logic [1:0]  phase_ff;
  logic        ads_n_ff, local_n_ff, rdy_o_ff, rdy_oe_ff;
  logic        req_ready_ff, done_ff, size8_ff, top_ff;
  logic [23:1] addr_ff;
  logic [2:0]  cyc_ff;
  logic [1:0]  bytes_ff;
  logic [6:1]  sel_n_ff;
  logic        tend;
  logic        start;

  function automatic logic [4:1] io_sel(input logic [23:1] a);
    logic [15:0] ia;
    ia = {a[15:1], 1'b0};
    io_sel[cbd_pkg::SEL_KBD]  = (ia == cbd_pkg::IO_KBD_A) || (ia == cbd_pkg::IO_KBD_B);
    io_sel[cbd_pkg::SEL_RTC]  = (ia >= cbd_pkg::IO_RTC_LO) && (ia <= cbd_pkg::IO_RTC_HI);
    io_sel[cbd_pkg::SEL_IDE1] = (ia >= cbd_pkg::IO_ID1_LO) && (ia <= cbd_pkg::IO_ID1_HI);
    io_sel[cbd_pkg::SEL_IDE0] = (ia >= cbd_pkg::IO_ID0_LO) && (ia <= cbd_pkg::IO_ID0_HI);
  endfunction

  assign tend  = (phase_ff == cbd_pkg::PH_LAST);
  assign start = (st_ff == HS_IDLE) && tend && req_valid && !bus.cpu_reset;

  // Phase follows the device's reset so both ends agree on T-state edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= cbd_pkg::PH_FIRST;
    end else if (bus.cpu_reset) begin
      phase_ff <= cbd_pkg::PH_FIRST;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff      <= HS_IDLE;
      ads_n_ff   <= 1'b1;
      local_n_ff <= 1'b1;
      addr_ff    <= '0;
      cyc_ff     <= 3'h0;
      bytes_ff   <= 2'h3;
      sel_n_ff   <= 6'h3f;
      top_ff     <= 1'b0;
    end else begin
      case (st_ff)
        HS_IDLE: begin
          if (start) begin
            st_ff      <= HS_T1;
            ads_n_ff   <= 1'b0;
            local_n_ff <= !req_local;
            addr_ff    <= req_addr;
            cyc_ff     <= req_cyc;
            bytes_ff   <= req_bytes;
            top_ff     <= req_cyc[2] && (req_mem == cbd_pkg::MSEL_TOP);
            sel_n_ff   <= 6'h3f;
            if (!req_cyc[2]) begin
              sel_n_ff[4:1] <= ~io_sel(req_addr);
            end else begin
              sel_n_ff[cbd_pkg::SEL_DRAM]  <= (req_mem != cbd_pkg::MSEL_DRAM);
              sel_n_ff[cbd_pkg::SEL_FLASH] <= (req_mem != cbd_pkg::MSEL_FLASH);
            end
          end
        end
        HS_T1: begin
          if (tend) begin
            st_ff    <= HS_T2;
            ads_n_ff <= 1'b1;
          end
        end
        HS_T2: begin
          if (tend && !bus.ready_line) begin
            st_ff      <= HS_IDLE;
            local_n_ff <= 1'b1;
            sel_n_ff   <= 6'h3f;
            top_ff     <= 1'b0;
          end
        end
        default: st_ff <= HS_IDLE;
      endcase
    end
  end

  // Local cycles end on our own ready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_o_ff  <= 1'b1;
      rdy_oe_ff <= 1'b0;
    end else if (st_ff == HS_T2 && !local_n_ff && !(tend && !bus.ready_line)) begin
      rdy_o_ff  <= 1'b0;
      rdy_oe_ff <= (phase_ff == cbd_pkg::PH_READY) || rdy_oe_ff;
    end else begin
      rdy_o_ff  <= 1'b1;
      rdy_oe_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_ready_ff <= 1'b0;
      done_ff      <= 1'b0;
      size8_ff     <= 1'b0;
    end else begin
      req_ready_ff <= (st_ff == HS_IDLE) && !start && !bus.cpu_reset;
      done_ff      <= (st_ff == HS_T2) && tend && !bus.ready_line;
      if ((st_ff == HS_T2) && tend) begin
        // Device leaves 8-bit boot memory to us
        size8_ff <= !bus.size8_n || (BOOT_8BIT && top_ff);
      end
    end
  end

  assign bus.addr_strobe_n  = ads_n_ff;
  assign bus.addr           = addr_ff;
  assign bus.mem_or_io      = cyc_ff[2];
  assign bus.data_or_ctrl   = cyc_ff[1];
  assign bus.write_or_read  = cyc_ff[0];
  assign bus.byte_high_en_n = bytes_ff[1];
  assign bus.byte_low_en_n  = bytes_ff[0];
  assign bus.gen_sel_n      = sel_n_ff;
  assign bus.upper_sel_n    = !top_ff;
  assign bus.local_access_n = local_n_ff;
  assign bus.host_ready_o   = rdy_o_ff;
  assign bus.host_ready_oe  = rdy_oe_ff;
  assign req_ready          = req_ready_ff;
  assign done               = done_ff;
  assign done_size8         = size8_ff;

endmodule // cbd_host

// ---- cbd_dev.sv ----
// Functional notes
// - Processor reset is synchronized power good
// - Reset aligns bus tracker phase to processor
// - Cycle fields qualified by address strobe
// - Byte enables decode; upper byte may use low lane
// - Status bits decode into eight cycle types
// - Halt cycle: A1 low shutdown, high halt
// - Select five DRAM, six and upper flash
// - Processor maps selects one to four to I/O
// - Ready undriven during local bus accesses
// - Ready changes one phase into T-state
// - Ready forced high after sampled low
// - Next address asserted only in DRAM cycles
// - Size8 asserted phase three, released phase one
// - Processor itself takes 8-bit boot memory as size8
// - Bank from A19 or A23 per config
// - Multiplexed DRAM address row and column mapping
// - MA9 row A20, column A21 or A19
// - Board strap selects DRAM size scheme
// - Low and high column strobes per bank
// - DRAM write strobe only for writes
// - Address latch enable marks valid address
// - Read and write commands to expansion bus
// - Size8 for every 8-bit expansion bus access
`timescale 1ns/1ns
module cbd_dev (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Processor bus
  cbd_if.dev               bus,
  // Board inputs
  input  wire logic        power_good_in,
  input  wire logic        dram_size_sel,
  input  wire logic        seb_cs16_n,
  // DRAM
  output logic [10:0]      dram_addr_mux,
  output logic             row_strobe_n,
  output logic             col_strobe_a_lo_n,
  output logic             col_strobe_a_hi_n,
  output logic             col_strobe_b_lo_n,
  output logic             col_strobe_b_hi_n,
  output logic             dram_write_n,
  // Expansion bus
  output logic             addr_latch_en,
  output logic             io_read_n,
  output logic             io_write_n,
  output logic             mem_read_n,
  output logic             mem_write_n,
  // Cycle decode
  output cbd_pkg::cbd_cyc_e   cyc_type,
  output cbd_pkg::cbd_bytes_e byte_mode,
  output logic             shutdown_seen,
  output logic             halt_seen,
  output logic             upper_on_low
);

  typedef enum logic {
    DS_IDLE = 1'b0,
    DS_BUSY = 1'b1
  } cbd_dstate_e;

  cbd_dstate_e         st_ff;
  logic [1:0]          pg_sync_ff, sz_sync_ff, cs_sync_ff;
  logic                reset_ff;
  logic [1:0]          phase_ff;
  logic [23:1]         addr_ff;
  cbd_pkg::cbd_cyc_e   cyc_ff;
  cbd_pkg::cbd_bytes_e bytes_ff;
  logic                dram_ff, ref_ff, seb_ff, is8_ff;
  logic [3:0]          tcnt_ff;
  logic [5:0]          el_ff;
  logic                ready_ff, ready_oe_ff, na_ff, s8_ff;
  logic                ras_n_ff, we_n_ff;
  logic [3:0]          cas_n_ff;
  logic [10:0]         ma_ff;
  logic                ale_ff, ior_ff, iow_ff, mem_read_n_ff, mem_write_n_ff;
  logic                shut_ff, halt_ff, upl_ff;

  cbd_pkg::cbd_cyc_e   cyc_in;
  cbd_pkg::cbd_bytes_e bytes_in;
  logic                tend, cap, done, busy;
  logic                in_ref, in_dram, in_flash, in_halt, in_seb, in_8;
  logic [3:0]          waits_in;

  // Active-high strobes {b_hi, b_lo, a_hi, a_lo}
  function automatic logic [3:0] lanes(input logic bank_b, input cbd_pkg::cbd_bytes_e b);
    logic hi;
    logic lo;
    hi = (b == cbd_pkg::BYTES_WORD) || (b == cbd_pkg::BYTES_UPPER);
    lo = (b == cbd_pkg::BYTES_WORD) || (b == cbd_pkg::BYTES_LOWER);
    lanes = bank_b ? {hi, lo, 2'b00} : {2'b00, hi, lo};
  endfunction

  assign cyc_in   = cbd_pkg::cbd_cyc_e'({bus.mem_or_io, bus.data_or_ctrl, bus.write_or_read});
  assign bytes_in = cbd_pkg::cbd_bytes_e'({bus.byte_high_en_n, bus.byte_low_en_n});
  assign in_ref   = (bytes_in == cbd_pkg::BYTES_REFRESH);
  assign in_dram  = in_ref || !bus.gen_sel_n[cbd_pkg::SEL_DRAM];
  assign in_flash = !in_dram && (!bus.gen_sel_n[cbd_pkg::SEL_FLASH] || !bus.upper_sel_n);
  assign in_halt  = (cyc_in == cbd_pkg::CYC_HALT);
  assign in_seb   = !in_dram && !in_flash && !in_halt;
  // Fixed 8-bit devices, or expansion targets that do not claim 16 bits
  assign in_8     = in_seb && (!(&bus.gen_sel_n[3:1]) || cs_sync_ff[1]);

  always_comb begin
    waits_in = cbd_pkg::WAIT_SEB16;
    if (in_dram) begin
      waits_in = cbd_pkg::WAIT_DRAM;
    end else if (in_flash) begin
      waits_in = cbd_pkg::WAIT_FLASH;
    end else if (in_halt) begin
      waits_in = cbd_pkg::WAIT_HALT;
    end else if (in_8) begin
      waits_in = cbd_pkg::WAIT_SEB8;
    end
  end

  assign busy = (st_ff == DS_BUSY);
  assign tend = (phase_ff == cbd_pkg::PH_LAST);
  assign cap  = !busy && tend && !bus.addr_strobe_n && bus.local_access_n && !reset_ff;
  // Processor samples ready at the end of each T-state
  assign done = busy && tend && !ready_ff;

  // Board pins are asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pg_sync_ff <= 2'b00;
      sz_sync_ff <= 2'b00;
      cs_sync_ff <= 2'b00;
      reset_ff   <= 1'b1;
    end else begin
      pg_sync_ff <= {pg_sync_ff[0], power_good_in};
      sz_sync_ff <= {sz_sync_ff[0], dram_size_sel};
      cs_sync_ff <= {cs_sync_ff[0], seb_cs16_n};
      reset_ff   <= !pg_sync_ff[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= cbd_pkg::PH_FIRST;
    end else if (reset_ff) begin
      phase_ff <= cbd_pkg::PH_FIRST;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff    <= DS_IDLE;
      addr_ff  <= '0;
      cyc_ff   <= cbd_pkg::CYC_INTA;
      bytes_ff <= cbd_pkg::BYTES_REFRESH;
      dram_ff  <= 1'b0;
      ref_ff   <= 1'b0;
      seb_ff   <= 1'b0;
      is8_ff   <= 1'b0;
      tcnt_ff  <= cbd_pkg::WAIT_NONE;
      el_ff    <= '0;
    end else if (reset_ff) begin
      st_ff <= DS_IDLE;
    end else begin
      case (st_ff)
        DS_IDLE: begin
          if (cap) begin
            st_ff    <= DS_BUSY;
            addr_ff  <= bus.addr;
            cyc_ff   <= cyc_in;
            bytes_ff <= bytes_in;
            dram_ff  <= in_dram;
            ref_ff   <= in_ref;
            seb_ff   <= in_seb;
            is8_ff   <= in_8;
            tcnt_ff  <= waits_in;
            el_ff    <= '0;
          end
        end
        DS_BUSY: begin
          if (done) begin
            st_ff <= DS_IDLE;
          end
          if (tend && tcnt_ff != cbd_pkg::WAIT_NONE) begin
            tcnt_ff <= tcnt_ff - 4'h1;
          end
          if (el_ff != cbd_pkg::EL_MAX) begin
            el_ff <= el_ff + 6'h01;
          end
        end
        default: st_ff <= DS_IDLE;
      endcase
    end
  end

  // Ready, next address and size8 move only on fixed phases
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_ff    <= 1'b1;
      ready_oe_ff <= 1'b0;
      na_ff       <= 1'b1;
      s8_ff       <= 1'b1;
    end else begin
      ready_oe_ff <= bus.local_access_n && !reset_ff;
      if (phase_ff == cbd_pkg::PH_READY) begin
        if (busy && tcnt_ff == cbd_pkg::WAIT_NONE) begin
          ready_ff <= 1'b0;
          na_ff    <= !(dram_ff && !ref_ff);
        end else begin
          ready_ff <= 1'b1;
          na_ff    <= 1'b1;
        end
      end
      if (done) begin
        na_ff <= 1'b1;
      end
      if (phase_ff == cbd_pkg::PH_S8_SET && busy && is8_ff) begin
        s8_ff <= 1'b0;
      end else if (phase_ff == cbd_pkg::PH_S8_CLR && !busy) begin
        s8_ff <= 1'b1;
      end
    end
  end

  // DRAM strobes; refresh runs column strobes before row strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ras_n_ff <= 1'b1;
      cas_n_ff <= 4'hf;
      we_n_ff  <= 1'b1;
      ma_ff    <= '0;
    end else if (!busy || done || !dram_ff) begin
      ras_n_ff <= 1'b1;
      cas_n_ff <= 4'hf;
      we_n_ff  <= 1'b1;
    end else if (ref_ff) begin
      cas_n_ff <= 4'h0;
      ras_n_ff <= (el_ff < cbd_pkg::EL_REF_RAS);
      we_n_ff  <= 1'b1;
    end else begin
      ras_n_ff <= 1'b0;
      we_n_ff  <= !(cyc_ff == cbd_pkg::CYC_MEM_WR);
      if (el_ff >= cbd_pkg::EL_COL) begin
        ma_ff <= {addr_ff[22], sz_sync_ff[1] ? addr_ff[21] : addr_ff[19], addr_ff[18:10]};
      end else begin
        ma_ff <= {addr_ff[21], addr_ff[20], addr_ff[9:1]};
      end
      if (el_ff >= cbd_pkg::EL_CAS) begin
        // Strap high means two small banks split on A19
        cas_n_ff <= ~lanes(sz_sync_ff[1] ? addr_ff[cbd_pkg::BANK_BIT_SMALL]
                                         : addr_ff[cbd_pkg::BANK_BIT_LARGE], bytes_ff);
      end
    end
  end

  // Expansion bus address latch and commands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ale_ff  <= 1'b0;
      ior_ff  <= 1'b1;
      iow_ff  <= 1'b1;
      mem_read_n_ff <= 1'b1;
      mem_write_n_ff <= 1'b1;
    end else begin
      ale_ff <= !busy && !bus.addr_strobe_n && bus.local_access_n && !reset_ff;
      if (busy && seb_ff && !done && el_ff >= cbd_pkg::EL_CMD) begin
        ior_ff  <= !(cyc_ff == cbd_pkg::CYC_IO_RD);
        iow_ff  <= !(cyc_ff == cbd_pkg::CYC_IO_WR);
        mem_read_n_ff <= !(cyc_ff == cbd_pkg::CYC_MEM_RD || cyc_ff == cbd_pkg::CYC_CODE_RD);
        mem_write_n_ff <= !(cyc_ff == cbd_pkg::CYC_MEM_WR);
      end else begin
        ior_ff  <= 1'b1;
        iow_ff  <= 1'b1;
        mem_read_n_ff <= 1'b1;
        mem_write_n_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shut_ff <= 1'b0;
      halt_ff <= 1'b0;
      upl_ff  <= 1'b0;
    end else begin
      shut_ff <= cap && in_halt && !bus.addr[1];
      halt_ff <= cap && in_halt && bus.addr[1];
      // Upper byte steered to the low lane while an 8-bit cycle is busy
      upl_ff  <= busy && is8_ff && (bytes_ff == cbd_pkg::BYTES_UPPER);
    end
  end

  assign bus.cpu_reset    = reset_ff;
  assign bus.dev_ready_o  = ready_ff;
  assign bus.dev_ready_oe = ready_oe_ff;
  assign bus.next_addr_n  = na_ff;
  assign bus.size8_n      = s8_ff;
  assign dram_addr_mux     = ma_ff;
  assign row_strobe_n      = ras_n_ff;
  assign col_strobe_a_lo_n = cas_n_ff[0];
  assign col_strobe_a_hi_n = cas_n_ff[1];
  assign col_strobe_b_lo_n = cas_n_ff[2];
  assign col_strobe_b_hi_n = cas_n_ff[3];
  assign dram_write_n      = we_n_ff;
  assign addr_latch_en     = ale_ff;
  assign io_read_n         = ior_ff;
  assign io_write_n        = iow_ff;
  assign mem_read_n        = mem_read_n_ff;
  assign mem_write_n       = mem_write_n_ff;
  assign cyc_type          = cyc_ff;
  assign byte_mode         = bytes_ff;
  assign shutdown_seen     = shut_ff;
  assign halt_seen         = halt_ff;
  assign upper_on_low      = upl_ff;

endmodule // cbd_dev

// ---- cbd_asserts.sv ----
`timescale 1ns/1ns
module cbd_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Processor bus
  input wire logic       addr_strobe_n,
  input wire logic [6:1] gen_sel_n,
  input wire logic       local_access_n,
  input wire logic       cpu_reset,
  input wire logic       dev_ready_o,
  input wire logic       dev_ready_oe,
  input wire logic       ready_line,
  input wire logic       next_addr_n,
  input wire logic       size8_n
);
  // Phase in the T-state; held at zero so it lines up with both ends
  logic [1:0] ph_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_ff <= 2'h0;
    end else begin
      ph_ff <= cpu_reset ? 2'h0 : ph_ff + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ads_t1;
    $fell(addr_strobe_n) |-> ph_ff == 2'h0 ##1 !addr_strobe_n [*3] ##1 addr_strobe_n;
  endproperty
  a_ads_t1: assert property (p_ads_t1)
    else $error("strobe off phase");
  property p_ready_tri;
    !local_access_n |=> !dev_ready_oe;
  endproperty
  a_ready_tri: assert property (p_ready_tri)
    else $error("ready driven in local cycle");
  property p_ready_ph;
    dev_ready_oe && $past(dev_ready_oe) && dev_ready_o != $past(dev_ready_o) |-> ph_ff == 2'h1;
  endproperty
  a_ready_ph: assert property (p_ready_ph)
    else $error("ready moved off phase one");
  property p_ready_hi;
    !ready_line && dev_ready_oe && ph_ff == 2'h3 |-> ##2 ready_line [*3];
  endproperty
  a_ready_hi: assert property (p_ready_hi)
    else $error("ready not forced high");
  property p_na_dram;
    !next_addr_n |-> !gen_sel_n[5] && !dev_ready_o;
  endproperty
  a_na_dram: assert property (p_na_dram)
    else $error("next address outside dram");
  property p_s8_set;
    $fell(size8_n) |-> ph_ff == 2'h3;
  endproperty
  a_s8_set: assert property (p_s8_set)
    else $error("size8 set off phase");
  property p_s8_clr;
    $rose(size8_n) |-> ph_ff == 2'h1;
  endproperty
  a_s8_clr: assert property (p_s8_clr)
    else $error("size8 release off phase");
  property p_s8_seb;
    !size8_n |-> local_access_n && gen_sel_n[5];
  endproperty
  a_s8_seb: assert property (p_s8_seb)
    else $error("size8 on local or dram");
  c_na: cover property (!next_addr_n);
  c_s8: cover property ($fell(size8_n));
  c_loc: cover property (!local_access_n && !addr_strobe_n);
endmodule // cbd_asserts

// ---- cpu_bus_dram_interface_tb_top.sv ----
`timescale 1ns/1ns
module cpu_bus_dram_interface_tb_top;
  logic clk, nrst, power_good_in, dram_size_sel, seb_cs16_n;
  logic req_valid, req_local, req_ready, done, done_size8;
  cbd_pkg::cbd_cyc_e req_cyc, cyc_type;
  cbd_pkg::cbd_bytes_e req_bytes, byte_mode;
  cbd_pkg::cbd_msel_e req_mem;
  logic [23:1] req_addr;
  logic [10:0] dram_addr_mux, row_v, col_v;
  logic row_strobe_n, dram_write_n, cas_al, cas_ah, cas_bl, cas_bh;
  logic addr_latch_en, io_read_n, io_write_n, mem_read_n, mem_write_n;
  logic shutdown_seen, halt_seen, upper_on_low, ras_p, we_v, ale_v, uol_v, sd_v, ht_v;
  logic [3:0] cas_v, cas_p, cmd_v;
  logic [31:0] r;
  int mismatches, n_tests, seed, k;
  wire [3:0] cas_n = {cas_bh, cas_bl, cas_ah, cas_al};
  logic [15:0] io_tab [8] = '{16'h0060, 16'h0064, 16'h0070, 16'h03f6,
                              16'h01f0, 16'h01f6, 16'h0200, 16'h0300};
  cbd_if cbd_if_inst ();
  cbd_host cbd_host_inst (.clk(clk), .nrst(nrst), .bus(cbd_if_inst.host),
    .req_valid(req_valid), .req_cyc(req_cyc), .req_bytes(req_bytes), .req_addr(req_addr),
    .req_local(req_local), .req_mem(req_mem), .req_ready(req_ready), .done(done),
    .done_size8(done_size8));
  cbd_dev cbd_dev_inst (.clk(clk), .nrst(nrst), .bus(cbd_if_inst.dev),
    .power_good_in(power_good_in), .dram_size_sel(dram_size_sel), .seb_cs16_n(seb_cs16_n),
    .dram_addr_mux(dram_addr_mux), .row_strobe_n(row_strobe_n), .col_strobe_a_lo_n(cas_al),
    .col_strobe_a_hi_n(cas_ah), .col_strobe_b_lo_n(cas_bl), .col_strobe_b_hi_n(cas_bh),
    .dram_write_n(dram_write_n), .addr_latch_en(addr_latch_en), .io_read_n(io_read_n),
    .io_write_n(io_write_n), .mem_read_n(mem_read_n), .mem_write_n(mem_write_n),
    .cyc_type(cyc_type), .byte_mode(byte_mode), .shutdown_seen(shutdown_seen),
    .halt_seen(halt_seen), .upper_on_low(upper_on_low));
  cbd_asserts cbd_asserts_inst (.clk(clk), .nrst(nrst),
    .addr_strobe_n(cbd_if_inst.addr_strobe_n), .gen_sel_n(cbd_if_inst.gen_sel_n),
    .local_access_n(cbd_if_inst.local_access_n), .cpu_reset(cbd_if_inst.cpu_reset),
    .dev_ready_o(cbd_if_inst.dev_ready_o), .dev_ready_oe(cbd_if_inst.dev_ready_oe),
    .ready_line(cbd_if_inst.ready_line), .next_addr_n(cbd_if_inst.next_addr_n),
    .size8_n(cbd_if_inst.size8_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [3:0] exp_cas(input logic [23:1] a, input logic [1:0] b);
    return (dram_size_sel ? a[19] : a[23]) ? {b, 2'b11} : {2'b11, b};
  endfunction
  function automatic logic [3:0] exp_cmd(input cbd_pkg::cbd_cyc_e c);
    return (c == cbd_pkg::CYC_IO_RD) ? 4'h8 : (c == cbd_pkg::CYC_IO_WR) ? 4'h4 :
           (c == cbd_pkg::CYC_MEM_WR) ? 4'h1 : c[2] ? 4'h2 : 4'h0;
  endfunction
  // Sampled after the edge so pulses of one cycle are not lost
  always @(posedge clk) #1 begin
    if (ras_p && !row_strobe_n) row_v = dram_addr_mux;
    if (cas_p == 4'hf && cas_n != 4'hf) begin
      col_v = dram_addr_mux;
      cas_v = cas_n;
      we_v = dram_write_n;
    end
    ale_v |= addr_latch_en;
    cmd_v |= ~{io_read_n, io_write_n, mem_read_n, mem_write_n};
    uol_v |= upper_on_low;
    sd_v |= shutdown_seen;
    ht_v |= halt_seen;
    ras_p = row_strobe_n;
    cas_p = cas_n;
  end
  task automatic run_req(input cbd_pkg::cbd_cyc_e c, input cbd_pkg::cbd_bytes_e b,
                         input logic [23:1] a, input logic l, input cbd_pkg::cbd_msel_e m);
    logic mem, seb, s8;
    mem = c inside {cbd_pkg::CYC_CODE_RD, cbd_pkg::CYC_MEM_RD, cbd_pkg::CYC_MEM_WR};
    seb = !l && b != cbd_pkg::BYTES_REFRESH && c != cbd_pkg::CYC_HALT && (!mem || m == 0);
    s8 = seb && (seb_cs16_n ||
                 (!mem && {a[15:1], 1'b0} inside {16'h0060, 16'h0064, 16'h0070, 16'h03f6}));
    for (k = 0; req_ready !== 1'b1 && k < 99; k++) @(negedge clk);
    {req_valid, req_addr, req_local} = {1'b1, a, l};
    req_cyc = c;
    req_bytes = b;
    req_mem = m;
    {ale_v, uol_v, sd_v, ht_v, cmd_v, cas_v, row_v, col_v} = '0;
    for (k = 0; req_ready !== 1'b0 && k < 99; k++) @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; done !== 1'b1 && k < 199; k++) @(negedge clk);
    check(done, 1'b1);
    if (!l) begin
      check(cyc_type, c);
      check(byte_mode, b);
      check(ale_v, 1'b1);
      check(done_size8, s8);
      check(uol_v, s8 && b == cbd_pkg::BYTES_UPPER);
      check({sd_v, ht_v}, (c == cbd_pkg::CYC_HALT) ? {!a[1], a[1]} : 2'b00);
    end
    if (seb) check(cmd_v, exp_cmd(c));
    if (!seb) check(cmd_v, 4'h0);
    if (!l && mem && m == cbd_pkg::MSEL_DRAM && b == cbd_pkg::BYTES_REFRESH) check(cas_v, 4'h0);
    if (!l && mem && m == cbd_pkg::MSEL_DRAM && b != cbd_pkg::BYTES_REFRESH) begin
      check(row_v, {a[21:20], a[9:1]});
      check(col_v, {a[22], dram_size_sel ? a[21] : a[19], a[18:10]});
      check(cas_v, exp_cas(a, b));
      check(we_v, c != cbd_pkg::CYC_MEM_WR);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
  initial begin
    {nrst, power_good_in, dram_size_sel, seb_cs16_n, req_valid, req_local} = '0;
    {req_addr, ras_p, cas_p} = '1;
    seed = 52;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(cbd_if_inst.cpu_reset, 1'b1);
    power_good_in = 1'b1;
    for (k = 0; cbd_if_inst.cpu_reset !== 1'b0 && k < 9; k++) @(negedge clk);
    check(k, 3);
    run_req(cbd_pkg::CYC_HALT, cbd_pkg::BYTES_WORD, 23'h00_0000, 1'b0, cbd_pkg::MSEL_NONE);
    run_req(cbd_pkg::CYC_MEM_RD, cbd_pkg::BYTES_REFRESH, 23'h12_3456, 1'b0, cbd_pkg::MSEL_DRAM);
    for (int i = 0; i < 8; i++) begin
      dram_size_sel = i[0];
      run_req(cbd_pkg::cbd_cyc_e'(i[2:0]), cbd_pkg::BYTES_UPPER, 23'h7f_ffff, 1'b0,
              cbd_pkg::MSEL_DRAM);
    end
    for (int i = 0; i < 150; i++) begin
      r = $random(seed);
      {dram_size_sel, seb_cs16_n} = r[11:10];
      req_addr = $random(seed);
      if (r[2:1] == 2'b01) req_addr = {8'h00, io_tab[r[14:12]][15:1]};
      if (r[4:3] == 2'b11) r[6:0] = 7'b01_11110;
      run_req(cbd_pkg::cbd_cyc_e'(r[2:0]), cbd_pkg::cbd_bytes_e'(r[4:3]), req_addr,
              r[9:7] == 3'h0, cbd_pkg::cbd_msel_e'(r[6:5]));
    end
    give_verdict();
  end
endmodule // cpu_bus_dram_interface_tb_top
